// ===== src/irq_regs.svh
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH
`define CTL_GLOBAL_EN 7
`define CTL_GROUP_EN 6
`define CTL_T0_EN 5
`define CTL_EXT_EN 4
`define CTL_PC_EN 3
`define CTL_T0_FLAG 2
`define CTL_EXT_FLAG 1
`define CTL_PC_FLAG 0
`define PIE_IMPL_MASK 8'h7F
`define OPT_EDGE_BIT 0
`define LINK_CTL 8'h00
`define LINK_PIE 8'h01
`define LINK_SEL 8'h02
`define LINK_OPT 8'h03
`define CTL_RESET 8'h00
`define PIE_RESET 8'h00
`define SEL_RESET 8'h00
`define OPT_EDGE_RESET 1'b1
`define AV_CTL 4'h0
`define AV_PIE 4'h1
`define AV_SEL 4'h2
`define AV_OPT 4'h3
`define AV_PFLAG 4'h4
`define AV_STAT 4'h5
`define AV_MASK 4'h6
`define AV_REQ 4'h7
`define EV_T0 0
`define EV_EXT 1
`define EV_PC 2
`define EV_PERIPH 3
`endif

// ===== src/irq_pkg.sv
package irq_pkg;
  typedef enum logic [1:0] {
    idle,
    answer
  } bus_state_t;
endpackage : irq_pkg

// ===== src/irq_link_if.sv
`timescale 1ns/1ps
interface irq_link_if;
  logic [7:0] reg_addr;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic timer_zero_rollover;
  logic ext_pin;
  logic [7:0] port_pins;
  logic [6:0] periph_flags;
  logic irq_request;
  modport device (
    input reg_addr, reg_write, reg_read, reg_wdata, timer_zero_rollover, ext_pin, port_pins, periph_flags,
    output reg_rdata, reg_ack, irq_request
  );
  modport core (
    output reg_addr, reg_write, reg_read, reg_wdata, timer_zero_rollover, ext_pin, port_pins, periph_flags,
    input reg_rdata, reg_ack, irq_request
  );
endinterface : irq_link_if

// ===== src/core_interrupt_enable_logic.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "irq_regs.svh"
// Notes on behaviour
// - Flags set regardless of any enable
// - Software clears flags before enabling sources
// - Global enable bit 7 gates every irq_request source, but not the sequencer's timer-zero path to irq
// - Group enable bit 6 gates peripheral sources
// - Bit 5 unmasks timer-zero overflow flag
// - Bit 4 unmasks external pin flag
// - Bit 3 plus per-pin select unmask changes
// - Rollover sets bit 2; only software clears
// - Reset leaves timer-zero count untouched
// - External pin event sets bit 1
// - Monitored pin change sets bit 0
// - Peripheral enable bits six down to zero
// - Peripheral enable bit 7 reads zero
// - Edge select chooses rising or falling edge
module core_interrupt_enable_logic #(
  // Register width.
  parameter int REG_W = 8,
  // Number of monitored port pins.
  parameter int N_PINS = 8,
  // Number of peripheral sources behind the group enable.
  parameter int N_PERIPH = 7
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the core.
  irq_link_if.device link
);
  // All state of the block lives in this one record.
  typedef struct packed {
    logic [REG_W-1:0] ctl;
    logic [REG_W-1:0] pie;
    logic [N_PINS-1:0] sel;
    logic edge_sel;
    logic ext_meta;
    logic ext_stable;
    logic ext_prev;
    logic [N_PINS-1:0] port_meta;
    logic [N_PINS-1:0] port_stable;
    logic [N_PINS-1:0] port_prev;
    logic [REG_W-1:0] rdata;
    logic ack;
    logic irq;
  } state_t;

  // Value taken at reset; the edge option starts on rising edges.
  localparam state_t RESET_STATE = '{
    ctl: `CTL_RESET,
    pie: `PIE_RESET,
    sel: `SEL_RESET,
    edge_sel: `OPT_EDGE_RESET,
    default: '0
  };

  state_t s_reg;
  state_t s_next;

  // Event detection.
  logic ext_edge;
  logic [N_PINS-1:0] pin_changed;
  logic port_change_seen;

  // Per-source requests before the global gate.
  logic [N_PERIPH-1:0] periph_hit;
  logic timer_zero_req;
  logic ext_pin_req;
  logic port_change_req;
  logic periph_req;
  logic core_req;

  // Each pin is compared with its own previous synchronised level.
  // A pin that is not selected never reaches the flag, so noisy unused pins are harmless.
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < N_PINS; pin_idx++) begin : g_pin_change
      assign pin_changed[pin_idx] =
        (s_reg.port_stable[pin_idx] ^ s_reg.port_prev[pin_idx]) & s_reg.sel[pin_idx];
    end
  endgenerate

  // Each peripheral flag is unmasked by its own enable bit.
  // The top enable bit is never stored, so it cannot unmask anything.
  genvar src_idx;
  generate
    for (src_idx = 0; src_idx < N_PERIPH; src_idx++) begin : g_periph_gate
      assign periph_hit[src_idx] = s_reg.pie[src_idx] & link.periph_flags[src_idx];
    end
  endgenerate

  // Any selected pin that toggled raises the port-change event.
  assign port_change_seen = |pin_changed;

  // The edge option picks which transition of the external pin counts.
  // Only the second synchroniser stage and its delayed copy are compared.
  assign ext_edge = s_reg.edge_sel ? (s_reg.ext_stable & ~s_reg.ext_prev)
                                   : (~s_reg.ext_stable & s_reg.ext_prev);

  // A core source requests only while both its flag and its enable are set.
  assign timer_zero_req = s_reg.ctl[`CTL_T0_EN] & s_reg.ctl[`CTL_T0_FLAG];
  assign ext_pin_req = s_reg.ctl[`CTL_EXT_EN] & s_reg.ctl[`CTL_EXT_FLAG];
  assign port_change_req = s_reg.ctl[`CTL_PC_EN] & s_reg.ctl[`CTL_PC_FLAG];

  // Peripheral sources pass only while the group enable is set.
  assign periph_req = s_reg.ctl[`CTL_GROUP_EN] & (|periph_hit);

  // All sources merge here; the global gate is applied when registering.
  assign core_req = timer_zero_req | ext_pin_req | port_change_req | periph_req;

  always_comb begin
    s_next = s_reg;

    // External pin synchroniser: the first stage feeds only the second.
    s_next.ext_meta = link.ext_pin;
    s_next.ext_stable = s_reg.ext_meta;
    s_next.ext_prev = s_reg.ext_stable;

    // Port pin synchronisers, same structure as the external pin.
    s_next.port_meta = link.port_pins[N_PINS-1:0];
    s_next.port_stable = s_reg.port_meta;
    s_next.port_prev = s_reg.port_stable;

    // The acknowledge is a single-cycle pulse one cycle after the request.
    s_next.ack = 1'b0;

    if (link.reg_write) begin
      s_next.ack = 1'b1;
      case (link.reg_addr)
        `LINK_CTL: begin
          s_next.ctl = link.reg_wdata;
        end
        `LINK_PIE: begin
          s_next.pie = link.reg_wdata & `PIE_IMPL_MASK;
        end
        `LINK_SEL: begin
          s_next.sel = link.reg_wdata[N_PINS-1:0];
        end
        `LINK_OPT: begin
          s_next.edge_sel = link.reg_wdata[`OPT_EDGE_BIT];
        end
        default: begin
          // Writes to unused indices are acknowledged and dropped.
          s_next.ack = 1'b1;
        end
      endcase
    end else if (link.reg_read) begin
      s_next.ack = 1'b1;
      case (link.reg_addr)
        `LINK_CTL: begin
          s_next.rdata = s_reg.ctl;
        end
        `LINK_PIE: begin
          s_next.rdata = s_reg.pie & `PIE_IMPL_MASK;
        end
        `LINK_SEL: begin
          s_next.rdata = REG_W'(s_reg.sel);
        end
        `LINK_OPT: begin
          s_next.rdata = REG_W'(s_reg.edge_sel);
        end
        default: begin
          // Unused indices read as zero.
          s_next.rdata = '0;
        end
      endcase
    end

    // Flag sets come after the register write so that a hardware set wins
    // over a software clear landing in the same cycle; no event is ever lost.
    // Flags are set whatever the enables say, so software can poll them.
    // The timer count itself is kept outside, so reset here loads the registers and flags but never the count.
    if (link.timer_zero_rollover) begin
      s_next.ctl[`CTL_T0_FLAG] = 1'b1;
    end
    if (ext_edge) begin
      s_next.ctl[`CTL_EXT_FLAG] = 1'b1;
    end
    if (port_change_seen) begin
      s_next.ctl[`CTL_PC_FLAG] = 1'b1;
    end

    // The request is registered so the core sees a glitch-free level.
    s_next.irq = s_reg.ctl[`CTL_GLOBAL_EN] & core_req;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output comes straight from the state record.
  assign link.reg_rdata = s_reg.rdata;
  assign link.reg_ack = s_reg.ack;
  assign link.irq_request = s_reg.irq;
endmodule : core_interrupt_enable_logic

// ===== src/core_irq_sequencer.sv
`timescale 1ns/1ps
`include "irq_regs.svh"
module core_irq_sequencer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the interrupt logic.
  irq_link_if.core link,
  // Event sources.
  input wire logic timer_zero_rollover,
  input wire logic ext_pin,
  input wire logic [7:0] port_pins,
  input wire logic [6:0] periph_flags,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt.
  output logic irq
);
  typedef struct packed {
    irq_pkg::bus_state_t st;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [31:0] rdata;
    logic wait_n;
    logic [3:0] stat;
    logic [3:0] mask;
    logic req_prev;
    logic irq;
  } state_t;
  state_t s_reg;
  state_t s_next;
  logic [3:0] ev;
  assign link.timer_zero_rollover = timer_zero_rollover;
  assign link.ext_pin = ext_pin;
  assign link.port_pins = port_pins;
  assign link.periph_flags = periph_flags;
  assign link.reg_addr = s_reg.addr;
  assign link.reg_write = s_reg.wr;
  assign link.reg_read = s_reg.rd;
  assign link.reg_wdata = s_reg.wdata;
  always_comb begin
    s_next = s_reg;
    s_next.wait_n = 1'b0;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    ev = 4'h0;
    ev[`EV_T0] = timer_zero_rollover;
    ev[`EV_PERIPH] = link.irq_request & ~s_reg.req_prev;
    s_next.req_prev = link.irq_request;
    case (s_reg.st)
      irq_pkg::idle: begin
        if ((avs_read | avs_write) & ~s_reg.wait_n) begin
          case (avs_address)
            `AV_STAT: begin
              s_next.wait_n = 1'b1;
              s_next.rdata = {28'h0000000, s_reg.stat};
              if (avs_write) s_next.stat = s_reg.stat & ~avs_writedata[3:0];
            end
            `AV_MASK: begin
              s_next.wait_n = 1'b1;
              s_next.rdata = {28'h0000000, s_reg.mask};
              if (avs_write) s_next.mask = avs_writedata[3:0];
            end
            `AV_REQ: begin
              s_next.wait_n = 1'b1;
              s_next.rdata = {31'h00000000, link.irq_request};
            end
            `AV_CTL, `AV_PIE, `AV_SEL, `AV_OPT: begin
              s_next.st = irq_pkg::answer;
              s_next.addr = {4'h0, avs_address};
              s_next.wr = avs_write;
              s_next.rd = avs_read;
              s_next.wdata = avs_writedata[7:0];
            end
            default: begin
              s_next.wait_n = 1'b1;
              s_next.rdata = 32'h00000000;
            end
          endcase
        end
      end
      irq_pkg::answer: begin
        if (link.reg_ack) begin
          s_next.st = irq_pkg::idle;
          s_next.wait_n = 1'b1;
          s_next.rdata = {24'h000000, link.reg_rdata};
        end
      end
      default: s_next.st = irq_pkg::idle;
    endcase
    s_next.stat = s_next.stat | ev;
    s_next.irq = |(s_next.stat & s_next.mask);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = ~s_reg.wait_n;
  assign irq = s_reg.irq;
endmodule : core_irq_sequencer

// ===== tb/irq_link_assertions.sv
`timescale 1ns/1ps
module irq_link_assertions (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link signals.
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic irq_request
);
  logic gie_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_reg <= 1'b0;
    end else if (reg_write && reg_addr == 8'h00) begin
      gie_reg <= reg_wdata[7];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pie_read;
    reg_read && reg_addr == 8'h01 ##1 reg_ack;
  endsequence
  a_ack_follows_req: assert property ((reg_write || reg_read) |=> reg_ack) else $error("ack late");
  a_ack_one_pulse: assert property (reg_ack |=> !reg_ack) else $error("ack too long");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_write || reg_read)) else $error("stray ack");
  a_write_one_pulse: assert property (reg_write |=> !reg_write) else $error("write too long");
  a_rw_exclusive: assert property (!(reg_write && reg_read)) else $error("read and write");
  a_gie_blocks_req: assert property (!gie_reg [*3] |-> !irq_request) else $error("irq while off");
  a_pie_msb_zero: assert property (s_pie_read |-> reg_rdata[7] == 1'b0) else $error("bit7 set");
  a_req_low_reset: assert property ($rose(rst_n) |-> !irq_request) else $error("irq at reset");
endmodule : irq_link_assertions

// ===== tb/core_interrupt_enable_logic_bench.sv
`timescale 1ns/1ps
module core_interrupt_enable_logic_bench;
  logic sys_clk, rst_n, t0, ext, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] pins;
  logic [6:0] pf;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  int n_errors, n_compared, cycles;
  irq_link_if link();
  core_interrupt_enable_logic i_core_interrupt_enable_logic (.sys_clk(sys_clk), .rst_n(rst_n), .link(link));
  core_irq_sequencer i_core_irq_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .timer_zero_rollover(t0), .ext_pin(ext), .port_pins(pins), .periph_flags(pf), .avs_address(addr),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  irq_link_assertions i_irq_link_assertions (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(link.reg_addr),
    .reg_write(link.reg_write), .reg_read(link.reg_read), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .irq_request(link.irq_request));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task summarize;
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h000000, d};
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    addr <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    chk(what, exp, rdata);
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : rdc
  task wait_sync;
    repeat (4) @(posedge sys_clk);
  endtask : wait_sync
  task pulse_t0;
    t0 <= 1'b1;
    @(posedge sys_clk);
    t0 <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse_t0
  task t_reset_and_pie;
    rdc(4'h0, 32'h00000000, "ctl");
    rdc(4'h3, 32'h00000001, "edge");
    wr(4'h1, 8'hFF);
    rdc(4'h1, 32'h0000007F, "pie");
    wr(4'hF, 8'hFF);
    rdc(4'hF, 32'h00000000, "unmapped");
  endtask : t_reset_and_pie
  task t_flags;
    pulse_t0();
    chk("req", 32'h0, {31'h0, link.irq_request});
    rdc(4'h0, 32'h00000004, "t0flag");
    rdc(4'h0, 32'h00000004, "t0hold");
    wr(4'h0, 8'h00);
    ext <= 1'b1;
    wait_sync();
    rdc(4'h0, 32'h00000002, "rise");
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    ext <= 1'b0;
    wait_sync();
    rdc(4'h0, 32'h00000002, "fall");
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h01);
    pins <= 8'h02;
    wait_sync();
    rdc(4'h0, 32'h00000000, "unsel");
    pins <= 8'h03;
    wait_sync();
    rdc(4'h0, 32'h00000001, "pchg");
    wr(4'h0, 8'h00);
  endtask : t_flags
  task t_gating;
    wr(4'h5, 8'h0F);
    wr(4'h6, 8'h01);
    chk("irqpre", 32'h0, {31'h0, irq});
    pulse_t0();
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h5, 8'h01);
    chk("irqclr", 32'h0, {31'h0, irq});
    wr(4'h0, 8'h24);
    chk("nogie", 32'h0, {31'h0, link.irq_request});
    wr(4'h0, 8'hA4);
    chk("t0en", 32'h1, {31'h0, link.irq_request});
    wr(4'h0, 8'h84);
    chk("t0off", 32'h0, {31'h0, link.irq_request});
    wr(4'h0, 8'h82);
    chk("extoff", 32'h0, {31'h0, link.irq_request});
    wr(4'h0, 8'h92);
    chk("exten", 32'h1, {31'h0, link.irq_request});
    wr(4'h0, 8'h89);
    chk("pcen", 32'h1, {31'h0, link.irq_request});
    pf <= 7'h01;
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h80);
    chk("nogrp", 32'h0, {31'h0, link.irq_request});
    wr(4'h0, 8'hC0);
    chk("grp", 32'h1, {31'h0, link.irq_request});
    wr(4'h1, 8'h02);
    chk("pmask", 32'h0, {31'h0, link.irq_request});
  endtask : t_gating
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {rst_n, t0, ext, avs_read, avs_write} = 5'h00;
    {pins, pf, addr, wdata, n_errors, n_compared, cycles} = '0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_and_pie();
    t_flags();
    t_gating();
    summarize();
  end
endmodule : core_interrupt_enable_logic_bench
